// ==== rtl/settle_timer.sv ====
// one conversion period timer: settled drops on restart and rises again
// after CYCLES + 1 clock edges; assumes restart is a pulse on clk
`timescale 1ns/1ps
module settle_timer #(
	parameter int CYCLES = 3125000
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// control
	input wire logic restart,
	output logic settled
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LOAD = W'(CYCLES);

	logic [W-1:0] cnt_r;

	always_ff @(posedge clk) begin
		if (srst || restart) begin
			cnt_r <= LOAD;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst || restart) begin
			settled <= 1'b0;
		end else if (cnt_r == '0) begin
			settled <= 1'b1;
		end
	end
endmodule

// ==== rtl/temp_alarm.sv ====
// temperature alarm core: trip registers, configuration, status flags with
// hysteresis and the open-drain alarm pin; register accesses arrive from the
// two-wire bus engine on link_clk, readings arrive from the converter on clk
`timescale 1ns/1ps

// Functional notes
// (RL1) bit 0 picks interrupt or comparator output
// (RL2) bit 2 picks all bands or critical only
// (RL3) hysteresis bits 10:9 shift every threshold
// (RL4) bit 6 locks window, bit 7 locks critical
// (RL5) pin undriven until output enable set
// (RL6) bit 1 picks active level
// (RL7) bit 4 reads status, bit 5 clears
// (RL8) mode bits frozen while output enabled
// (RL9) host disables output before changing mode
// (RL10) asserted output holds through shutdown
// (RL11) temperature bits 15,14,13 show bands
// (RL12) critical band forces comparator behaviour
// (RL13) hysteresis applies when leaving a band; code enters the lower band below lower minus hysteresis, leaves at lower
// (RL14) upper trip at 02h, lower at 03h
// (RL15) window crossings raise an event when enabled
// (RL16) clear bit or alert response ends event
// (RL17) host keeps upper above lower
// (RL18) wait one conversion after window writes
// (RL19) host waits 125 ms before enabling
// (RL20) critical trip at 04h, holds until below
// (RL21) critical alarm ignores clear and alert response
// (RL22) host keeps critical above upper
// (RL23) host sequence: critical, wait, enable, read
// (RL24) clear ends interrupt until next trigger
// (RL25) comparator output ignores register accesses
// (RL26) locked band trip writes are ignored
module temp_alarm
	import alarm_pkg::*;
#(
	parameter int CONV_CLKS = CONV_CYCLES
) (
	// core clock and reset
	input wire logic clk,
	input wire logic srst,
	// converter readings
	input wire logic temp_valid,
	input wire logic [12:0] temp_code,
	// register access from the bus engine
	input wire logic link_clk,
	input wire logic link_srst,
	input wire logic acc_req,
	input wire logic acc_we,
	input wire logic acc_ara,
	input wire logic [7:0] acc_addr,
	input wire logic [15:0] acc_wdata,
	output logic acc_busy,
	output logic acc_done,
	output logic [15:0] acc_rdata,
	// alarm pin
	output logic event_o,
	output logic event_oe
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [15:0] cfg_r, upper_r, lower_r, crit_r, temp_r;
	logic crit_flag_r, above_r, below_r, evt_r;
	logic above_nxt, below_nxt, crit_nxt;
	logic settled, win_wr, alarm_act, drive_low;
	logic req_pulse, req_we, req_ara;
	logic [7:0] req_addr;
	logic [15:0] req_wdata, rd_data;
	logic [25:0] req_payload;
	logic cfg_wr, clr_req, ara_req, enabled, int_mode, crit_only, shdn;
	logic signed [13:0] t_s, up_s, lo_s, cr_s, hys_s;

	function automatic logic signed [13:0] to_s14(input logic [15:0] v);
		to_s14 = {v[TEMP_MSB], v[TEMP_MSB:0]};
	endfunction

	// ----------------------------------------------------------------
	// link crossing
	// ----------------------------------------------------------------
	xfer_hs #(.PW(26), .AW(16)) u_xfer (
		.src_clk(link_clk),
		.src_srst(link_srst),
		.src_start(acc_req),
		.src_payload({acc_we, acc_ara, acc_addr, acc_wdata}),
		.src_busy(acc_busy),
		.src_done(acc_done),
		.src_answer(acc_rdata),
		.dst_clk(clk),
		.dst_srst(srst),
		.dst_pulse(req_pulse),
		.dst_payload(req_payload),
		.dst_answer(rd_data)
	);

	assign req_we = req_payload[25];
	assign req_ara = req_payload[24];
	assign req_addr = req_payload[23:16];
	assign req_wdata = req_payload[15:0];

	assign cfg_wr = req_pulse && req_we && !req_ara && req_addr == OFS_CFG;
	assign clr_req = cfg_wr && req_wdata[CFG_CLR];
	assign ara_req = req_pulse && req_ara;
	assign enabled = cfg_r[CFG_OE];
	assign int_mode = cfg_r[CFG_MODE];
	assign crit_only = cfg_r[CFG_CRIT_ONLY];
	assign shdn = cfg_r[CFG_SHDN];

	// ----------------------------------------------------------------
	// configuration register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_r <= CFG_RST;
		end else if (cfg_wr) begin
			cfg_r <= req_wdata & CFG_WMASK;
			if (enabled && req_wdata[CFG_OE]) begin
				cfg_r[CFG_MODE] <= cfg_r[CFG_MODE]; // RL8
				cfg_r[CFG_CRIT_ONLY] <= cfg_r[CFG_CRIT_ONLY]; // RL8
			end
		end
	end

	// ----------------------------------------------------------------
	// trip registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			upper_r <= TRIP_RST;
			lower_r <= TRIP_RST;
		end else if (req_pulse && req_we && !req_ara && !cfg_r[CFG_WIN_LOCK]) begin // RL4 RL26
			if (req_addr == OFS_UPPER) begin
				upper_r <= req_wdata; // RL14
			end else if (req_addr == OFS_LOWER) begin
				lower_r <= req_wdata; // RL14
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			crit_r <= TRIP_RST;
		end else if (req_pulse && req_we && !req_ara && req_addr == OFS_CRIT
				&& !cfg_r[CFG_CRIT_LOCK]) begin // RL4 RL26
			crit_r <= req_wdata; // RL20
		end
	end

	assign win_wr = req_pulse && req_we && !req_ara
		&& (req_addr == OFS_UPPER || req_addr == OFS_LOWER || req_addr == OFS_CRIT);

	settle_timer #(.CYCLES(CONV_CLKS)) u_settle (
		.clk(clk),
		.srst(srst),
		.restart(win_wr),
		.settled(settled)
	);

	// ----------------------------------------------------------------
	// reading and band flags
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			temp_r <= '0;
		end else if (temp_valid) begin
			temp_r <= {3'h0, temp_code};
		end
	end

	always_comb begin
		case (cfg_r[CFG_HYS_HI:CFG_HYS_LO]) // RL3
			2'h0: hys_s = HYS_STEP0;
			2'h1: hys_s = HYS_STEP1;
			2'h2: hys_s = HYS_STEP2;
			default: hys_s = HYS_STEP3;
		endcase
	end

	assign t_s = to_s14(temp_r);
	assign up_s = to_s14(upper_r);
	assign lo_s = to_s14(lower_r);
	assign cr_s = to_s14(crit_r);

	always_comb begin
		crit_nxt = crit_flag_r;
		if (t_s >= cr_s) begin
			crit_nxt = 1'b1;
		end else if (t_s < cr_s - hys_s) begin // RL13
			crit_nxt = 1'b0;
		end
		above_nxt = above_r;
		if (t_s > up_s) begin
			above_nxt = 1'b1;
		end else if (t_s <= up_s - hys_s) begin // RL13
			above_nxt = 1'b0;
		end
		below_nxt = below_r;
		if (t_s < lo_s - hys_s) begin // RL13
			below_nxt = 1'b1;
		end else if (t_s >= lo_s) begin
			below_nxt = 1'b0;
		end
	end

	// flags follow the stored reading once the window has settled and while not in shutdown
	always_ff @(posedge clk) begin
		if (srst) begin
			crit_flag_r <= 1'b0;
			above_r <= 1'b0;
			below_r <= 1'b0;
		end else if (settled && !shdn) begin // RL18 RL10
			crit_flag_r <= crit_nxt; // RL20
			above_r <= above_nxt;
			below_r <= below_nxt;
		end
	end

	// ----------------------------------------------------------------
	// interrupt event latch
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			evt_r <= 1'b0;
		end else if (settled && !shdn && enabled
				&& (above_nxt != above_r || below_nxt != below_r)) begin
			evt_r <= 1'b1; // RL15
		end else if ((clr_req || ara_req) && !shdn) begin
			evt_r <= 1'b0; // RL16 RL24
		end
	end

	// ----------------------------------------------------------------
	// alarm output
	// ----------------------------------------------------------------
	// critical band overrides the mode and cannot be cleared
	always_comb begin
		if (crit_flag_r) begin
			alarm_act = 1'b1; // RL12 RL21
		end else if (crit_only) begin
			alarm_act = 1'b0; // RL2
		end else if (int_mode) begin
			alarm_act = evt_r; // RL1
		end else begin
			alarm_act = above_r || below_r; // RL1 RL25
		end
	end

	assign drive_low = cfg_r[CFG_POL] ? !alarm_act : alarm_act; // RL6

	always_ff @(posedge clk) begin
		if (srst) begin
			event_oe <= 1'b0;
		end else begin
			event_oe <= enabled && drive_low; // RL5
		end
	end

	assign event_o = 1'b0;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb begin
		if (req_addr == OFS_CFG) begin
			rd_data = cfg_r;
			rd_data[CFG_STAT] = alarm_act; // RL7
		end else if (req_addr == OFS_UPPER) begin
			rd_data = upper_r;
		end else if (req_addr == OFS_LOWER) begin
			rd_data = lower_r;
		end else if (req_addr == OFS_CRIT) begin
			rd_data = crit_r;
		end else if (req_addr == OFS_TEMP) begin
			rd_data = temp_r;
			rd_data[TEMP_CRIT_BIT] = crit_flag_r; // RL11
			rd_data[TEMP_ABOVE_BIT] = above_r; // RL11
			rd_data[TEMP_BELOW_BIT] = below_r; // RL11
		end else begin
			rd_data = '0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_win_write;
		win_wr;
	endsequence

	sequence s_hold_off;
		!settled [*8];
	endsequence

	a_pin_disabled: assert property (@(posedge clk) disable iff (srst) // RL5
		!enabled |=> !event_oe)
		else $error("alarm pin driven while output disabled");

	a_settle_wait: assert property (@(posedge clk) disable iff (srst) // RL18
		s_win_write |=> s_hold_off)
		else $error("comparison resumed too soon after window write");

	a_mode_frozen: assert property (@(posedge clk) disable iff (srst) // RL8
		enabled && cfg_wr && req_wdata[CFG_OE]
		|=> cfg_r[CFG_MODE] == $past(cfg_r[CFG_MODE])
		&& cfg_r[CFG_CRIT_ONLY] == $past(cfg_r[CFG_CRIT_ONLY]))
		else $error("mode bits changed while output enabled");

	a_crit_hold: assert property (@(posedge clk) disable iff (srst) // RL21
		crit_flag_r && (clr_req || ara_req) |=> alarm_act)
		else $error("critical alarm cleared by clear request");

	a_shdn_hold: assert property (@(posedge clk) disable iff (srst) // RL10
		shdn && alarm_act && !req_pulse |=> alarm_act)
		else $error("alarm dropped during shutdown");

	a_win_lock: assert property (@(posedge clk) disable iff (srst) // RL26
		cfg_r[CFG_WIN_LOCK] && req_pulse && req_we |=> $stable(upper_r) && $stable(lower_r))
		else $error("locked window trip changed");

	// the flag may fall again one cycle later when a reading below the critical trip minus hysteresis arrives
	a_crit_set: assert property (@(posedge clk) disable iff (srst) // RL20
		settled && !shdn && t_s >= cr_s |=> crit_flag_r && alarm_act)
		else $error("critical flag not set at threshold");

	a_evt_cross: assert property (@(posedge clk) disable iff (srst) // RL15
		settled && !shdn && enabled && above_nxt != above_r |=> evt_r)
		else $error("window crossing raised no event");

	a_clear_evt: assert property (@(posedge clk) disable iff (srst) // RL16 RL24
		(clr_req || ara_req) && !shdn
		&& !(settled && enabled && (above_nxt != above_r || below_nxt != below_r))
		|=> !evt_r)
		else $error("event latch not cleared by clear request");

	a_low_active: assert property (@(posedge clk) disable iff (srst) // RL6
		enabled && alarm_act && !cfg_r[CFG_POL] |=> event_oe || !$past(alarm_act))
		else $error("active low alarm not driven");

	// a clear written in comparator mode must leave alarm_act where the flags put it
	a_cmp_steady: assert property (@(posedge clk) disable iff (srst) // RL25
		!int_mode && !crit_only && clr_req
		&& !req_wdata[CFG_MODE] && !req_wdata[CFG_CRIT_ONLY]
		|=> alarm_act == $past(alarm_act)
		|| !$stable(above_r) || !$stable(below_r) || !$stable(crit_flag_r))
		else $error("comparator output moved on register access");
endmodule

// ==== rtl/xfer_hs.sv ====
// toggle handshake carrying one request word from the link domain to the
// core domain and one answer word back; the payload is held until answered
`timescale 1ns/1ps
module xfer_hs #(
	parameter int PW = 26,
	parameter int AW = 16
) (
	// link side
	input wire logic src_clk,
	input wire logic src_srst,
	input wire logic src_start,
	input wire logic [PW-1:0] src_payload,
	output logic src_busy,
	output logic src_done,
	output logic [AW-1:0] src_answer,
	// core side
	input wire logic dst_clk,
	input wire logic dst_srst,
	output logic dst_pulse,
	output logic [PW-1:0] dst_payload,
	input wire logic [AW-1:0] dst_answer
);
	logic req_tgl_r, ack_s1_r, ack_s2_r, ack_seen_r;
	logic req_s1_r, req_s2_r, req_seen_r, ack_tgl_r;
	logic [PW-1:0] pay_r;
	logic [AW-1:0] ans_hold_r;

	// ----------------------------------------------------------------
	// link domain
	// ----------------------------------------------------------------
	assign src_busy = req_tgl_r != ack_seen_r;

	always_ff @(posedge src_clk) begin
		if (src_srst) begin
			req_tgl_r <= 1'b0;
			pay_r <= '0;
		end else if (src_start && !src_busy) begin
			req_tgl_r <= ~req_tgl_r;
			pay_r <= src_payload;
		end
	end

	always_ff @(posedge src_clk) begin
		if (src_srst) begin
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
			ack_seen_r <= 1'b0;
			src_done <= 1'b0;
			src_answer <= '0;
		end else begin
			ack_s1_r <= ack_tgl_r;
			ack_s2_r <= ack_s1_r;
			src_done <= ack_s2_r != ack_seen_r;
			if (ack_s2_r != ack_seen_r) begin
				ack_seen_r <= ack_s2_r;
				src_answer <= ans_hold_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// core domain
	// ----------------------------------------------------------------
	assign dst_pulse = req_s2_r != req_seen_r;
	assign dst_payload = pay_r;

	always_ff @(posedge dst_clk) begin
		if (dst_srst) begin
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
			req_seen_r <= 1'b0;
			ack_tgl_r <= 1'b0;
			ans_hold_r <= '0;
		end else begin
			req_s1_r <= req_tgl_r;
			req_s2_r <= req_s1_r;
			if (dst_pulse) begin
				req_seen_r <= req_s2_r;
				ack_tgl_r <= req_s2_r;
				ans_hold_r <= dst_answer;
			end
		end
	end
endmodule

// ==== shared/alarm_pkg.sv ====
// constants for the temperature alarm block: register map, field positions,
// reset values and conversion timing; used by the alarm core and its bench
package alarm_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int CONV_MS = 125;
	localparam int CONV_CYCLES = (CLK_HZ / 1000) * CONV_MS;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CFG = 8'h01;
	localparam logic [7:0] OFS_UPPER = 8'h02;
	localparam logic [7:0] OFS_LOWER = 8'h03;
	localparam logic [7:0] OFS_CRIT = 8'h04;
	localparam logic [7:0] OFS_TEMP = 8'h05;

	// ----------------------------------------------------------------
	// configuration fields
	// ----------------------------------------------------------------
	localparam int CFG_MODE = 0;
	localparam int CFG_POL = 1;
	localparam int CFG_CRIT_ONLY = 2;
	localparam int CFG_OE = 3;
	localparam int CFG_STAT = 4;
	localparam int CFG_CLR = 5;
	localparam int CFG_WIN_LOCK = 6;
	localparam int CFG_CRIT_LOCK = 7;
	localparam int CFG_SHDN = 8;
	localparam int CFG_HYS_LO = 9;
	localparam int CFG_HYS_HI = 10;
	localparam logic [15:0] CFG_WMASK = 16'h07CF;

	// ----------------------------------------------------------------
	// temperature word fields
	// ----------------------------------------------------------------
	localparam int TEMP_CRIT_BIT = 15;
	localparam int TEMP_ABOVE_BIT = 14;
	localparam int TEMP_BELOW_BIT = 13;
	localparam int TEMP_MSB = 12;

	// ----------------------------------------------------------------
	// reset values and hysteresis steps (1/16 degree units)
	// ----------------------------------------------------------------
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam logic [15:0] TRIP_RST = 16'h0000;
	localparam logic signed [13:0] HYS_STEP0 = 14'sh0000;
	localparam logic signed [13:0] HYS_STEP1 = 14'sh0018;
	localparam logic signed [13:0] HYS_STEP2 = 14'sh0030;
	localparam logic signed [13:0] HYS_STEP3 = 14'sh0060;

endpackage

// ==== test/bus_host.sv ====
// host stand-in on the link side: one register access at a time
// assumes link_clk and link_srst come from the bench
`timescale 1ns/1ps
module bus_host (
	// link clock and reset
	input wire logic link_clk,
	input wire logic link_srst,
	// access port
	output logic acc_req,
	output logic acc_we,
	output logic acc_ara,
	output logic [7:0] acc_addr,
	output logic [15:0] acc_wdata,
	input wire logic acc_busy,
	input wire logic acc_done,
	input wire logic [15:0] acc_rdata
);
	initial begin
		{acc_req, acc_we, acc_ara, acc_addr, acc_wdata} = 27'h0000000;
	end
	// qualifiers stay put until done; a lost answer reads as unknown
	task automatic xfer(input logic we, input logic ara, input logic [7:0] a,
		input logic [15:0] wd, output logic [15:0] rd);
		int n;
		n = 0;
		@(posedge link_clk);
		#1;
		while (acc_busy !== 1'h0 || link_srst !== 1'h0) begin
			@(posedge link_clk);
			#1;
		end
		{acc_req, acc_we, acc_ara, acc_addr, acc_wdata} = {1'h1, we, ara, a, wd};
		@(posedge link_clk);
		#1;
		acc_req = 1'h0;
		while (acc_done !== 1'h1 && n < 64) begin
			@(posedge link_clk);
			#1;
			n++;
		end
		rd = (n < 64) ? acc_rdata : 16'hXXXX;
		// released address and data lines show a changed pattern, not the last value
		acc_addr = ~a;
		acc_wdata = ~wd;
	endtask
endmodule

// ==== test/temp_alarm_tb.sv ====
// self-checking bench: feeds readings, steers the host stand-in and
// compares pin and flags with a reference model
// assumes alarm_pkg, temp_alarm and bus_host are compiled first
`timescale 1ns/1ps
module temp_alarm_tb
	import alarm_pkg::*;
();
	localparam int CONV = 20;
	logic clk, srst, link_clk, link_srst, temp_valid, acc_req, acc_we, acc_ara;
	logic acc_busy, acc_done, event_o, event_oe;
	logic [12:0] temp_code;
	logic [7:0] acc_addr;
	logic [15:0] acc_wdata, acc_rdata, rd, cfg_m, exp_v;
	logic crit_f, abv_f, blw_f, ev_m;
	int up_m, lo_m, cr_m, settle_m, cyc = 0, mismatches = 0, n_compared = 0;
	int hys_t[4] = '{0, 24, 48, 96};
	int q[$];

	temp_alarm #(.CONV_CLKS(CONV)) uut (.clk(clk), .srst(srst), .temp_valid(temp_valid),
		.temp_code(temp_code), .link_clk(link_clk), .link_srst(link_srst), .acc_req(acc_req),
		.acc_we(acc_we), .acc_ara(acc_ara), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
		.acc_busy(acc_busy), .acc_done(acc_done), .acc_rdata(acc_rdata), .event_o(event_o),
		.event_oe(event_oe));
	bus_host host (.link_clk(link_clk), .link_srst(link_srst), .acc_req(acc_req),
		.acc_we(acc_we), .acc_ara(acc_ara), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
		.acc_busy(acc_busy), .acc_done(acc_done), .acc_rdata(acc_rdata));

	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	initial begin
		link_clk = 1'h0;
		#13;
		forever #32 link_clk = ~link_clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			results();
		end
	end

	// ----
	// reference model
	// ----
	function automatic logic m_act();
		return crit_f | (!cfg_m[CFG_CRIT_ONLY] & (cfg_m[CFG_MODE] ? ev_m : abv_f | blw_f));
	endfunction
	task automatic m_temp(input int t);
		logic pa, pb;
		int h;
		if (settle_m > 0 || cfg_m[CFG_SHDN]) return;
		h = hys_t[cfg_m[10:9]];
		{pa, pb} = {abv_f, blw_f};
		if (t >= cr_m) crit_f = 1'h1;
		else if (t < cr_m - h) crit_f = 1'h0;
		if (t > up_m) abv_f = 1'h1;
		else if (t <= up_m - h) abv_f = 1'h0;
		if (t < lo_m - h) blw_f = 1'h1;
		else if (t >= lo_m) blw_f = 1'h0;
		if (cfg_m[CFG_OE] && {pa, pb} != {abv_f, blw_f}) ev_m = 1'h1;
	endtask
	task automatic m_wr(input logic [7:0] a, input logic [15:0] d);
		if (a == OFS_CFG) begin
			if (d[CFG_CLR] && !cfg_m[CFG_SHDN]) ev_m = 1'h0;
			if (cfg_m[CFG_OE] && d[CFG_OE]) d = (d & ~16'h0005) | (cfg_m & 16'h0005);
			cfg_m = d & CFG_WMASK;
		end
		if (a inside {OFS_UPPER, OFS_LOWER, OFS_CRIT}) settle_m = CONV + 4;
		if (a == OFS_UPPER && !cfg_m[CFG_WIN_LOCK]) up_m = d;
		if (a == OFS_LOWER && !cfg_m[CFG_WIN_LOCK]) lo_m = d;
		if (a == OFS_CRIT && !cfg_m[CFG_CRIT_LOCK]) cr_m = d;
	endtask

	// ----
	// checks and stimulus
	// ----
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		host.xfer(1'h1, 1'h0, a, d, rd);
		m_wr(a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string w);
		host.xfer(1'h0, 1'h0, a, 16'h0000, rd);
		chk(rd, e, w);
	endtask
	task automatic ara();
		host.xfer(1'h0, 1'h1, OFS_TEMP, 16'h0000, rd);
		if (!cfg_m[CFG_SHDN]) ev_m = 1'h0;
	endtask
	task automatic pin();
		logic e;
		e = cfg_m[CFG_OE] & (cfg_m[CFG_POL] ? !m_act() : m_act());
		chk({15'h0000, event_oe}, {15'h0000, e}, "event_oe");
		chk({15'h0000, event_o}, 16'h0000, "event_o");
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		settle_m -= n;
	endtask
	// one reading, then pin and status flags
	task automatic tc(input int t);
		@(posedge clk);
		#1;
		temp_valid = 1'h1;
		temp_code = t[12:0];
		@(posedge clk);
		#1;
		temp_valid = 1'h0;
		m_temp(t);
		repeat (3) @(posedge clk);
		#1;
		pin();
		host.xfer(1'h0, 1'h0, OFS_TEMP, 16'h0000, rd);
		chk(rd & 16'hE000, {crit_f, abv_f, blw_f, 13'h0000}, "flags");
	endtask

	initial begin
		{srst, link_srst, temp_valid, temp_code} = {1'h1, 1'h1, 1'h0, 13'h0000};
		cfg_m = 16'h0000;
		up_m = 0;
		lo_m = 0;
		cr_m = 0;
		settle_m = CONV + 4;
		{crit_f, abv_f, blw_f, ev_m} = 4'h0;
		void'($urandom(32'h0D2B));
		repeat (12) @(posedge clk);
		#1;
		srst = 1'h0;
		link_srst = 1'h0;
		pin();
		// reading and critical trip both start at zero: critical flag sets once settled
		idle(30);
		m_temp(0);
		for (int a = 1; a < 7; a++) begin
			exp_v = 16'h0000;
			if (a == 1) exp_v[CFG_STAT] = m_act();
			if (a == 5) exp_v[15:13] = {crit_f, abv_f, blw_f};
			rdc(a[7:0], exp_v, "reset_value");
		end
		$display("test reset done");
		wr(OFS_UPPER, 16'h0550);
		wr(OFS_LOWER, 16'h0140);
		wr(OFS_CRIT, 16'h05F0);
		rdc(OFS_UPPER, 16'h0550, "upper");
		rdc(OFS_LOWER, 16'h0140, "lower");
		rdc(OFS_CRIT, 16'h05F0, "crit");
		idle(30);
		wr(OFS_CFG, 16'h0008);
		tc(16'h0300);
		tc(16'h0600);
		rdc(OFS_CFG, cfg_m | {11'h000, m_act(), 4'h0}, "status");
		pin();
		tc(16'h0540);
		for (int i = 0; i < 8; i++) tc($urandom_range(16'h0700, 16'h0100));
		$display("test comparator done");
		for (int h = 0; h < 4; h++) begin
			wr(OFS_CFG, {5'h00, h[1:0], 9'h008});
			q = '{16'h0560, 16'h0551 - hys_t[h], 16'h0550 - hys_t[h], 16'h0140 - hys_t[h],
				16'h013F - hys_t[h], 16'h013F, 16'h0140};
			foreach (q[k]) tc(q[k]);
		end
		$display("test hysteresis done");
		wr(OFS_CFG, 16'h0020);
		wr(OFS_CFG, 16'h0009);
		tc(16'h0600);
		wr(OFS_CFG, 16'h0029);
		pin();
		wr(OFS_CFG, 16'h000C);
		tc(16'h0300);
		ara();
		pin();
		tc(16'h0600);
		wr(OFS_CFG, 16'h0029);
		tc(16'h05F0);
		wr(OFS_CFG, 16'h0029);
		pin();
		ara();
		pin();
		tc(16'h05E0);
		$display("test interrupt done");
		wr(OFS_CFG, 16'h0000);
		wr(OFS_CFG, 16'h000A);
		tc(16'h0600);
		tc(16'h0300);
		wr(OFS_CFG, 16'h0008);
		tc(16'h0600);
		wr(OFS_CFG, 16'h0108);
		tc(16'h0300);
		wr(OFS_CFG, 16'h0008);
		tc(16'h0300);
		$display("test polarity and shutdown done");
		wr(OFS_CFG, 16'h00C8);
		wr(OFS_UPPER, 16'h0100);
		wr(OFS_CRIT, 16'h0100);
		rdc(OFS_UPPER, up_m[15:0], "upper_locked");
		rdc(OFS_CRIT, cr_m[15:0], "crit_locked");
		wr(OFS_CFG, 16'h0008);
		wr(OFS_UPPER, 16'h0200);
		tc(16'h0300);
		idle(30);
		tc(16'h0300);
		wr(OFS_CFG, 16'h0000);
		wr(OFS_CFG, 16'h000C);
		tc(16'h0300);
		tc(16'h0600);
		$display("test locks, settle and critical only done");
		results();
	end
endmodule
